/* File: shared/spsl_pkg.sv */
// package: register map, field layout, modes and timing for the serial port slave
// Operation
// - spi slave shifts on external clock edges
// - spi runs in sleep, byte wakes device
// - slave-select high resets spi logic
// - port acts only while enabled
// - mode field selects port personality
// - bus clock and data are glitch filtered
// - finished byte moves to buffer, flags event
// - byte before buffer read sets overflow
// - ten-bit header is 11110 a9 a8 0
// - match or data gets automatic acknowledge
// - no acknowledge when full or overflowed
// - full buffer kept, event and overflow set
// - buffer read clears full; software clears overflow
// - after start, eight bits on rising clock
// - eighth falling edge compares address bits
// - load at eighth fall, event at ninth
// - ten-bit byte sets update flag, holds clock
// - repeated start matches high byte only
// - write address clears direction, fills buffer
// - event per byte, software clears it
// - overflow with empty buffer loads, no acknowledge
// - pins are inputs, overridden when driving
// - reset disables port, abandons transfer
package spsl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SPIKE_NS = 50;
  localparam int unsigned FILT_RAW = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
  localparam int APB_AW = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_BUF = 8'h13;
  localparam logic [7:0] IDX_CTRL = 8'h14;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_ADDR = 8'h93;
  localparam logic [7:0] IDX_STAT = 8'h94;
  localparam logic [APB_AW-1:0] A_INTERRUPT_CONTROL = {2'h0, IDX_INTERRUPT_CONTROL, 2'h0};
  localparam logic [APB_AW-1:0] A_FLAGS = {2'h0, IDX_FLAGS, 2'h0};
  localparam logic [APB_AW-1:0] A_BUF = {2'h0, IDX_BUF, 2'h0};
  localparam logic [APB_AW-1:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [APB_AW-1:0] A_ENABLES = {2'h0, IDX_ENABLES, 2'h0};
  localparam logic [APB_AW-1:0] A_ADDR = {2'h0, IDX_ADDR, 2'h0};
  localparam logic [APB_AW-1:0] A_STAT = {2'h0, IDX_STAT, 2'h0};
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int EVT_BIT = 3;
  localparam logic [4:0] TENBIT_HDR = 5'h1E;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] MODE_SPI_SS = 4'h4;
  localparam logic [3:0] MODE_SPI_NOSS = 4'h5;
  localparam logic [3:0] MODE_I2C_7 = 4'h6;
  localparam logic [3:0] MODE_I2C_10 = 4'h7;
  localparam logic [3:0] MODE_I2C_MST = 4'h8;
  typedef struct packed {
    logic wcol; logic ov; logic en; logic ckp; logic [3:0] mode;
  } spsl_ctrl_s;
  typedef struct packed {
    logic smp; logic cke; logic da; logic stop; logic start; logic rw; logic ua; logic bf;
  } spsl_stat_s;
  typedef struct packed {
    logic scl_o; logic scl_oe; logic sda_o; logic sda_oe; logic sdo_o; logic sdo_oe;
  } spsl_pin_out_s;
  typedef enum logic [2:0] {
    I2_IDLE = 3'h0, I2_SHIFT = 3'h1, I2_ACK = 3'h3, I2_HOLD = 3'h2, I2_SKIP = 3'h6
  } spsl_i2c_state_e;
  function automatic logic is_spi_slave(input logic [3:0] m);
    return (m == MODE_SPI_SS) || (m == MODE_SPI_NOSS);
  endfunction
  function automatic logic is_i2c_slave(input logic [3:0] m);
    return (m == MODE_I2C_7) || (m == MODE_I2C_10);
  endfunction
endpackage

/* File: design/spsl_pin_sync.sv */
// two-stage pin synchroniser with optional glitch filter
`timescale 1ns/100ps
module spsl_pin_sync #(
  parameter int unsigned FILT = 0,
  parameter logic RST_VAL = 1'h1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;

  // only the second stage is looked at by anything
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
    end

  generate
    if (FILT == 0)
    begin : g_plain
      assign level_o = s2_reg;
    end
    else
    begin : g_filt
      logic lvl_reg;
      logic [3:0] cnt_reg;
      // a change must persist past the spike window before it counts
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
          lvl_reg <= RST_VAL;
          cnt_reg <= 4'h0;
        end
        else if (s2_reg == lvl_reg)
          cnt_reg <= 4'h0;
        else if (cnt_reg == 4'(FILT))
        begin
          lvl_reg <= s2_reg;
          cnt_reg <= 4'h0;
        end
        else
          cnt_reg <= cnt_reg + 4'h1;
      assign level_o = lvl_reg;
    end
  endgenerate
endmodule // spsl_pin_sync

/* File: design/spsl_spi_shift.sv */
// clocked-serial slave shifter on the sampled external clock
`timescale 1ns/100ps
module spsl_spi_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic ss_ctrl,
  input wire logic ss_high,
  input wire logic sck,
  input wire logic sdi,
  input wire logic ckp,
  input wire logic cke,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic byte_done,
  output logic [3:0] bit_cnt,
  output logic sdo_o,
  output logic sdo_oe
);
  import spsl_pkg::*;
  logic sck_d_reg;
  logic [7:0] rx_sr_reg;
  logic [7:0] tx_sr_reg;
  logic hold_rst;
  logic lead_edge;
  logic trail_edge;
  logic samp_edge;
  logic shift_edge;

  // idle level is ckp; leading edge leaves idle
  assign lead_edge = (sck != sck_d_reg) && (sck_d_reg == ckp);
  assign trail_edge = (sck != sck_d_reg) && (sck_d_reg != ckp);
  assign samp_edge = cke ? trail_edge : lead_edge;
  assign shift_edge = cke ? lead_edge : trail_edge;
  assign hold_rst = !active || (ss_ctrl && ss_high);
  assign sdo_o = tx_sr_reg[7];
  assign sdo_oe = !hold_rst;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sck_d_reg <= 1'h0;
    else
      sck_d_reg <= sck;

  // receive side: bits land on the sampling edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_sr_reg <= RST_BYTE;
      bit_cnt <= 4'h0;
      rx_byte <= RST_BYTE;
      byte_done <= 1'h0;
    end
    else
    begin
      byte_done <= 1'h0;
      if (hold_rst)
        bit_cnt <= 4'h0;
      else if (samp_edge)
      begin
        rx_sr_reg <= {rx_sr_reg[6:0], sdi};
        if (bit_cnt == BITS_PER_BYTE - 4'h1)
        begin
          bit_cnt <= 4'h0;
          rx_byte <= {rx_sr_reg[6:0], sdi};
          byte_done <= 1'h1;
        end
        else
          bit_cnt <= bit_cnt + 4'h1;
      end
    end

  // transmit side: no shift before the first sample so the msb is seen first
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_sr_reg <= RST_BYTE;
    else if (tx_load)
      tx_sr_reg <= tx_byte;
    else if (!hold_rst && shift_edge && bit_cnt != 4'h0)
      tx_sr_reg <= {tx_sr_reg[6:0], 1'h0};
endmodule // spsl_spi_shift

/* File: design/spsl_top.sv */
// serial port slave: apb registers, two-wire slave receiver, spi slave
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module spsl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spsl_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  output spsl_pkg::spsl_pin_out_s pins_o,
  input wire logic sleep_mode,
  output logic wake_o
);
  import spsl_pkg::*;
  spsl_ctrl_s ctrl_reg;
  spsl_stat_s stat_reg;
  spsl_i2c_state_e st_reg;
  logic [7:0] buf_reg;
  logic [7:0] addr_reg;
  logic [7:0] interrupt_control_reg;
  logic [7:0] enables_reg;
  logic evt_reg;
  logic [7:0] sr_reg;
  logic [3:0] cnt_reg;
  logic addressed_reg;
  logic phase_reg;
  logic tenbit_done_reg;
  logic ack_drv_reg;
  logic scl_f;
  logic sda_f;
  logic sck_s;
  logic sdi_s;
  logic ssn_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic i2c_on;
  logic spi_on;
  logic dec;
  logic take;
  logic is_addr;
  logic need_ua;
  logic hi_match;
  logic byte_in;
  logic byte_evt;
  logic rd_buf;
  logic wr_acc;
  logic setup;
  logic hit;
  logic [7:0] spi_rx;
  logic spi_done;
  logic [3:0] spi_cnt;
  logic sdo_o;
  logic sdo_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
    return (a == A_INTERRUPT_CONTROL) || (a == A_FLAGS) || (a == A_BUF) || (a == A_CTRL) ||
           (a == A_ENABLES) || (a == A_ADDR) || (a == A_STAT);
  endfunction

  // pins: bus lines filtered, spi lines only synchronised
  spsl_pin_sync #(.FILT(FILT_CYC), .RST_VAL(1'h1)) u_scl (
    .pclk(pclk), .presetn(presetn), .pin_i(scl_i), .level_o(scl_f));
  spsl_pin_sync #(.FILT(FILT_CYC), .RST_VAL(1'h1)) u_sda (
    .pclk(pclk), .presetn(presetn), .pin_i(sda_i), .level_o(sda_f));
  spsl_pin_sync #(.FILT(0), .RST_VAL(1'h0)) u_sck (
    .pclk(pclk), .presetn(presetn), .pin_i(sck_i), .level_o(sck_s));
  spsl_pin_sync #(.FILT(0), .RST_VAL(1'h0)) u_sdi (
    .pclk(pclk), .presetn(presetn), .pin_i(sdi_i), .level_o(sdi_s));
  spsl_pin_sync #(.FILT(0), .RST_VAL(1'h1)) u_ssn (
    .pclk(pclk), .presetn(presetn), .pin_i(ss_n_i), .level_o(ssn_s));

  // mode decode gates both engines
  assign i2c_on = ctrl_reg.en && is_i2c_slave(ctrl_reg.mode);
  assign spi_on = ctrl_reg.en && is_spi_slave(ctrl_reg.mode);

  // apb slave: zero wait, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign hit = addr_mapped(paddr);
  assign wr_acc = psel && penable && pwrite && hit;
  assign rd_buf = psel && penable && !pwrite && (paddr == A_BUF);
  assign pready = 1'h1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      case (paddr)
        A_INTERRUPT_CONTROL: prdata <= {24'h00_0000, interrupt_control_reg};
        A_FLAGS: prdata <= {24'h00_0000, 4'h0, evt_reg, 3'h0};
        A_BUF: prdata <= {24'h00_0000, buf_reg};
        A_CTRL: prdata <= {24'h00_0000, ctrl_reg};
        A_ENABLES: prdata <= {24'h00_0000, enables_reg};
        A_ADDR: prdata <= {24'h00_0000, addr_reg};
        A_STAT: prdata <= {24'h00_0000, stat_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end

  spsl_spi_shift u_spi (
    .pclk(pclk), .presetn(presetn), .active(spi_on),
    .ss_ctrl(ctrl_reg.mode == MODE_SPI_SS), .ss_high(ssn_s),
    .sck(sck_s), .sdi(sdi_s), .ckp(ctrl_reg.ckp), .cke(stat_reg.cke),
    .tx_load(wr_acc && paddr == A_BUF), .tx_byte(pwdata[7:0]),
    .rx_byte(spi_rx), .byte_done(spi_done), .bit_cnt(spi_cnt),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe));

  // bus condition detection on filtered levels
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
    end
    else
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  assign scl_rise = scl_f && !scl_d_reg;
  assign scl_fall = !scl_f && scl_d_reg;
  assign start_det = i2c_on && scl_f && scl_d_reg && sda_d_reg && !sda_f;
  assign stop_det = i2c_on && scl_f && scl_d_reg && !sda_d_reg && sda_f;

  // decision point is the falling edge of the eighth clock
  assign dec = i2c_on && st_reg == I2_SHIFT && scl_fall && cnt_reg == BITS_PER_BYTE;
  always_comb
  begin
    hi_match = sr_reg[7:3] == TENBIT_HDR && sr_reg[7:1] == addr_reg[7:1];
    is_addr = !addressed_reg;
    need_ua = 1'h0;
    if (addressed_reg)
      take = 1'h1;
    else if (ctrl_reg.mode == MODE_I2C_7)
      take = sr_reg[7:1] == addr_reg[7:1];
    else if (phase_reg)
    begin
      take = sr_reg == addr_reg;
      need_ua = take;
    end
    else
    begin
      // a fresh high byte must be a write; after a repeated start it stands alone
      take = hi_match && (tenbit_done_reg || !sr_reg[0]);
      need_ua = take && !tenbit_done_reg;
    end
  end
  assign byte_in = (dec && take) || spi_done;
  assign byte_evt = (i2c_on && st_reg == I2_ACK && scl_fall) || spi_done;

  // two-wire receive state machine
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      st_reg <= I2_IDLE;
    else if (!i2c_on)
      st_reg <= I2_IDLE;
    else if (stop_det)
      st_reg <= I2_IDLE;
    else if (start_det)
      st_reg <= I2_SHIFT;
    else
    begin
      case (st_reg)
        I2_IDLE: st_reg <= I2_IDLE;
        I2_SHIFT:
          if (dec)
            st_reg <= take ? I2_ACK : I2_SKIP;
        I2_ACK:
          if (scl_fall)
          begin
            if (stat_reg.ua)
              st_reg <= I2_HOLD;
            else if (stat_reg.rw)
              st_reg <= I2_SKIP;
            else
              st_reg <= I2_SHIFT;
          end
        I2_HOLD:
          if (!stat_reg.ua)
            st_reg <= I2_SHIFT;
        I2_SKIP: st_reg <= I2_SKIP;
        default: st_reg <= I2_IDLE;
      endcase
    end

  // bit counter and shift register, sampled on rising clock
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_reg <= 4'h0;
      sr_reg <= RST_BYTE;
    end
    else if (start_det || (st_reg == I2_ACK && scl_fall))
      cnt_reg <= 4'h0;
    else if (st_reg == I2_SHIFT && scl_rise && cnt_reg != BITS_PER_BYTE)
    begin
      sr_reg <= {sr_reg[6:0], sda_f};
      cnt_reg <= cnt_reg + 4'h1;
    end

  // addressing progress; ten-bit completion survives a repeated start
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      addressed_reg <= 1'h0;
      phase_reg <= 1'h0;
      tenbit_done_reg <= 1'h0;
    end
    else if (!i2c_on || stop_det)
    begin
      addressed_reg <= 1'h0;
      phase_reg <= 1'h0;
      tenbit_done_reg <= 1'h0;
    end
    else if (start_det)
    begin
      addressed_reg <= 1'h0;
      phase_reg <= 1'h0;
    end
    else if (dec && take && !addressed_reg)
    begin
      if (ctrl_reg.mode == MODE_I2C_10 && !phase_reg && !tenbit_done_reg)
        phase_reg <= 1'h1;
      else
      begin
        addressed_reg <= 1'h1;
        phase_reg <= 1'h0;
        if (phase_reg)
          tenbit_done_reg <= 1'h1;
      end
    end

  // acknowledge drive from eighth to ninth falling edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ack_drv_reg <= 1'h0;
    else if (!i2c_on || start_det || stop_det)
      ack_drv_reg <= 1'h0;
    else if (dec)
      ack_drv_reg <= take && !stat_reg.bf && !ctrl_reg.ov;
    else if (st_reg == I2_ACK && scl_fall)
      ack_drv_reg <= 1'h0;

  // buffer: hardware load on a byte, software write for transmit data
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      buf_reg <= RST_BYTE;
    else if (byte_in && !stat_reg.bf)
      buf_reg <= spi_done ? spi_rx : sr_reg;
    else if (wr_acc && paddr == A_BUF)
      buf_reg <= pwdata[7:0];

  // full flag: a load in the same cycle as a read keeps it set
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stat_reg.bf <= 1'h0;
    else if (byte_in && !stat_reg.bf)
      stat_reg.bf <= 1'h1;
    else if (rd_buf || !ctrl_reg.en)
      stat_reg.bf <= 1'h0;

  // update-address: set on each ten-bit address byte except the high byte after a repeated start, cleared by address write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stat_reg.ua <= 1'h0;
    else if (dec && need_ua)
      stat_reg.ua <= 1'h1;
    else if ((wr_acc && paddr == A_ADDR) || !i2c_on)
      stat_reg.ua <= 1'h0;

  // direction, data/address and bus condition status
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      stat_reg.rw <= 1'h0;
      stat_reg.da <= 1'h0;
      stat_reg.start <= 1'h0;
      stat_reg.stop <= 1'h0;
    end
    else if (!ctrl_reg.en)
    begin
      stat_reg.start <= 1'h0;
      stat_reg.stop <= 1'h0;
    end
    else
    begin
      if (dec && take)
      begin
        stat_reg.da <= !is_addr;
        // the low ten-bit address byte carries no direction bit
        if (is_addr && !phase_reg)
          stat_reg.rw <= sr_reg[0];
      end
      if (start_det)
      begin
        stat_reg.start <= 1'h1;
        stat_reg.stop <= 1'h0;
      end
      else if (stop_det)
      begin
        stat_reg.start <= 1'h0;
        stat_reg.stop <= 1'h1;
      end
    end

  // software-written status bits
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      stat_reg.smp <= 1'h0;
      stat_reg.cke <= 1'h0;
    end
    else if (wr_acc && paddr == A_STAT)
    begin
      stat_reg.smp <= pwdata[7];
      stat_reg.cke <= pwdata[6];
    end

  // control: overflow and collision are set by hardware, set beats clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_reg <= spsl_ctrl_s'(RST_BYTE);
    else
    begin
      if (wr_acc && paddr == A_CTRL)
        ctrl_reg <= spsl_ctrl_s'(pwdata[7:0]);
      if (byte_in && stat_reg.bf)
        ctrl_reg.ov <= 1'h1;
      if (wr_acc && paddr == A_BUF && spi_on && spi_cnt != 4'h0)
        ctrl_reg.wcol <= 1'h1;
    end

  // event flag: software clears by writing zero, a new event wins
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      evt_reg <= 1'h0;
    else if (byte_evt)
      evt_reg <= 1'h1;
    else if (wr_acc && paddr == A_FLAGS)
      evt_reg <= pwdata[EVT_BIT];

  // plain storage registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      interrupt_control_reg <= RST_BYTE;
      enables_reg <= RST_BYTE;
      addr_reg <= RST_BYTE;
    end
    else if (wr_acc)
    begin
      if (paddr == A_INTERRUPT_CONTROL)
        interrupt_control_reg <= pwdata[7:0];
      if (paddr == A_ENABLES)
        enables_reg <= pwdata[7:0];
      if (paddr == A_ADDR)
        addr_reg <= pwdata[7:0];
    end

  // wake request: any byte event (finished spi byte or accepted two-wire byte) while asleep
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wake_o <= 1'h0;
    else
      wake_o <= sleep_mode && byte_evt;

  // open-drain lines only ever pull low; nothing drives while disabled
  assign pins_o.scl_o = 1'h0;
  assign pins_o.scl_oe = i2c_on && st_reg == I2_HOLD;
  assign pins_o.sda_o = 1'h0;
  assign pins_o.sda_oe = i2c_on && ack_drv_reg;
  assign pins_o.sdo_o = sdo_o;
  assign pins_o.sdo_oe = sdo_oe;

  sequence s_full_byte;
    dec && take && stat_reg.bf;
  endsequence
  a_ovf_on_full: assert property (s_full_byte |=> ctrl_reg.ov && $stable(buf_reg))
    else $error("full buffer byte did not flag overflow or changed buffer");
  a_nack_blocked: assert property (dec && (stat_reg.bf || ctrl_reg.ov) |=> !pins_o.sda_oe)
    else $error("acknowledge given while full or overflowed");
  a_ack_match: assert property (dec && take && !stat_reg.bf && !ctrl_reg.ov
      |=> pins_o.sda_oe && stat_reg.bf && buf_reg == $past(sr_reg))
    else $error("matched byte not acknowledged and loaded");
  a_ovf_loads: assert property (dec && take && !stat_reg.bf && ctrl_reg.ov
      |=> !pins_o.sda_oe && buf_reg == $past(sr_reg))
    else $error("overflowed empty buffer handled wrongly");
  a_event_ninth: assert property (i2c_on && st_reg == I2_ACK && scl_fall |=> evt_reg)
    else $error("event flag not set at ninth falling edge");
  a_bf_read: assert property (rd_buf && !byte_in |=> !stat_reg.bf)
    else $error("buffer read did not clear full flag");
  a_ua_hold: assert property (stat_reg.ua && st_reg == I2_HOLD |-> pins_o.scl_oe)
    else $error("clock not held while address update pending");
  a_off_quiet: assert property (!ctrl_reg.en ##1 !ctrl_reg.en
      |-> !pins_o.scl_oe && !pins_o.sda_oe && st_reg == I2_IDLE)
    else $error("port active while disabled");
  a_ss_reset: assert property (ctrl_reg.mode == MODE_SPI_SS && ssn_s |=> spi_cnt == 4'h0)
    else $error("slave select high did not reset spi logic");
  a_wake_byte: assert property (spi_done && sleep_mode |=> wake_o ##1 !wake_o || byte_evt)
    else $error("received byte did not wake device");
  a_hdr_reject: assert property (dec && !addressed_reg && ctrl_reg.mode == MODE_I2C_10
      && !phase_reg && sr_reg[7:3] != TENBIT_HDR |=> st_reg == I2_SKIP)
    else $error("non-header byte accepted as ten-bit address");
endmodule // spsl_top

/* File: verif/spsl_i2c_master.sv */
// two-wire bus master model that drives the slave's clock and data lines
`timescale 1ns/100ps
module spsl_i2c_master (
  input wire logic pclk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda,
  output logic acked
);
  logic sda_drv;
  // open drain with pull-up: the line is low while either party pulls it
  assign sda = sda_drv & ~sda_oe;
  initial
  begin
    scl = 1'h1;
    sda_drv = 1'h1;
    acked = 1'h0;
  end
  // ten system clocks a quarter bit, well past the slave's glitch filter
  task automatic quarter();
    repeat (10) @(posedge pclk);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_drv <= 1'h1;
    quarter();
    scl <= 1'h1;
    quarter();
    sda_drv <= 1'h0;
    quarter();
    scl <= 1'h0;
    quarter();
  endtask
  // msb first, data changes only while the clock is low; ninth clock reads the ack
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv <= b[i];
      quarter();
      scl <= 1'h1;
      quarter();
      quarter();
      scl <= 1'h0;
      quarter();
    end
    sda_drv <= 1'h1;
    quarter();
    scl <= 1'h1;
    quarter();
    acked <= ~sda;
    quarter();
    scl <= 1'h0;
    quarter();
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_drv <= 1'h0;
    quarter();
    scl <= 1'h1;
    quarter();
    sda_drv <= 1'h1;
    quarter();
  endtask
endmodule // spsl_i2c_master

/* File: verif/spsl_top_test.sv */
// self-checking bench: apb register access and two-wire slave reception
`timescale 1ns/100ps
module spsl_top_test;
  import spsl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scl_m, sda_w, acked, err;
  logic sck, sdi, ss_n, sleep, wake;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] q;
  spsl_pin_out_s pins;
  int bad_count, n_compared, n_wake;
  spsl_top spsl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_m & ~pins.scl_oe), .sda_i(sda_w), .sck_i(sck),
    .sdi_i(sdi), .ss_n_i(ss_n), .pins_o(pins), .sleep_mode(sleep), .wake_o(wake));
  spsl_i2c_master spsl_i2c_master_i (.pclk(pclk), .sda_oe(pins.sda_oe), .scl(scl_m),
    .sda(sda_w), .acked(acked));
  always #50 pclk = ~pclk;
  // wake is a one-cycle pulse
  always @(posedge pclk)
    if (wake === 1'h1)
      n_wake <= n_wake + 1;
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // one apb transfer; waits for pready under a bound, then lets an edge pass
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [7:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      bad_count++;
      results();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [APB_AW-1:0] a, input logic [7:0] m,
    input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk(nm, e, q & m);
  endtask
  // reset values and an unmapped address
  task automatic t_regs();
    rd("control", A_CTRL, 8'hFF, 8'h00);
    rd("status", A_STAT, 8'hFF, 8'h00);
    rd("flags", A_FLAGS, 8'hFF, 8'h00);
    apb(1'h0, 12'h004, 8'h00);
    chk("unmapped err", 8'h01, {7'h00, err});
  endtask
  // 7-bit write address: ack, buffer load, direction clear, event, read clears full
  task automatic t_addr();
    apb(1'h1, A_ADDR, 8'hA4);
    apb(1'h1, A_CTRL, 8'h26);
    spsl_i2c_master_i.start();
    spsl_i2c_master_i.send_byte(8'hA4);
    chk("addr ack", 8'h01, {7'h00, acked});
    rd("addr event", A_FLAGS, 8'h08, 8'h08);
    rd("addr full rw", A_STAT, 8'h05, 8'h01);
    rd("addr buffer", A_BUF, 8'hFF, 8'hA4);
    rd("full cleared", A_STAT, 8'h01, 8'h00);
  endtask
  // second byte before read, then overflow with empty buffer
  task automatic t_ovf();
    apb(1'h1, A_FLAGS, 8'h00);
    spsl_i2c_master_i.send_byte(8'h3C);
    chk("data ack", 8'h01, {7'h00, acked});
    apb(1'h1, A_FLAGS, 8'h00);
    spsl_i2c_master_i.send_byte(8'h5A);
    chk("full nack", 8'h00, {7'h00, acked});
    rd("ovf set", A_CTRL, 8'h40, 8'h40);
    rd("ovf event", A_FLAGS, 8'h08, 8'h08);
    rd("buffer kept", A_BUF, 8'hFF, 8'h3C);
    spsl_i2c_master_i.send_byte(8'h77);
    chk("ovf nack", 8'h00, {7'h00, acked});
    rd("ovf load", A_BUF, 8'hFF, 8'h77);
    rd("ovf stays", A_CTRL, 8'h40, 8'h40);
    apb(1'h1, A_CTRL, 8'h26);
    rd("ovf cleared", A_CTRL, 8'hFF, 8'h26);
    spsl_i2c_master_i.stop();
  endtask
  // wrong address and a disabled port are both ignored
  task automatic t_ignore();
    apb(1'h1, A_FLAGS, 8'h00);
    spsl_i2c_master_i.start();
    spsl_i2c_master_i.send_byte(8'h10);
    chk("mismatch nack", 8'h00, {7'h00, acked});
    rd("mismatch event", A_FLAGS, 8'h08, 8'h00);
    spsl_i2c_master_i.stop();
    apb(1'h1, A_CTRL, 8'h06);
    spsl_i2c_master_i.start();
    spsl_i2c_master_i.send_byte(8'hA4);
    chk("disabled nack", 8'h00, {7'h00, acked});
    rd("disabled event", A_FLAGS, 8'h08, 8'h00);
    spsl_i2c_master_i.stop();
  endtask
  // ten-bit address with clock hold, then a repeated start
  task automatic t_ten();
    apb(1'h1, A_ADDR, 8'hF2);
    apb(1'h1, A_CTRL, 8'h27);
    spsl_i2c_master_i.start();
    spsl_i2c_master_i.send_byte(8'hF2);
    rd("hi st", A_STAT, 8'h07, 8'h03);
    chk("held", 8'h01, {7'h00, pins.scl_oe});
    apb(1'h1, A_ADDR, 8'h5B);
    rd("hi buf", A_BUF, 8'hFF, 8'hF2);
    spsl_i2c_master_i.send_byte(8'h5B);
    chk("lo ack", 8'h01, {7'h00, acked});
    rd("lo st", A_STAT, 8'h07, 8'h03);
    apb(1'h1, A_ADDR, 8'hF2);
    rd("lo buf", A_BUF, 8'hFF, 8'h5B);
    spsl_i2c_master_i.start();
    spsl_i2c_master_i.send_byte(8'hF3);
    rd("re st", A_STAT, 8'h07, 8'h05);
    rd("re buf", A_BUF, 8'hFF, 8'hF3);
    spsl_i2c_master_i.stop();
  endtask
  // msb first; the slave samples on the falling clock
  task automatic spi_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      sdi <= b[i];
      sck <= 1'h1;
      repeat (4) @(posedge pclk);
      sck <= 1'h0;
      repeat (4) @(posedge pclk);
    end
  endtask
  // spi with select: a cut byte is dropped, a whole one wakes
  task automatic t_spi();
    apb(1'h1, A_STAT, 8'h40);
    apb(1'h1, A_CTRL, 8'h24);
    apb(1'h1, A_FLAGS, 8'h00);
    chk("sdo off", 8'h00, {7'h00, pins.sdo_oe});
    apb(1'h1, A_BUF, 8'h80);
    chk("sdo msb", 8'h01, {7'h00, pins.sdo_o});
    sleep <= 1'h1;
    ss_n <= 1'h0;
    spi_bits(8'hF0, 4);
    ss_n <= 1'h1;
    repeat (6) @(posedge pclk);
    ss_n <= 1'h0;
    spi_bits(8'h96, 8);
    repeat (6) @(posedge pclk);
    rd("spi evt", A_FLAGS, 8'h08, 8'h08);
    rd("spi buf", A_BUF, 8'hFF, 8'h96);
    chk("wake", 8'h01, n_wake[7:0]);
  endtask
  // overall limit so a hang still reaches the report
  initial
  begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    results();
  end
  initial
  begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = '0;
    sck = 1'h0;
    sdi = 1'h0;
    ss_n = 1'h1;
    sleep = 1'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_addr();
    t_ovf();
    t_ignore();
    t_ten();
    t_spi();
    results();
  end
endmodule // spsl_top_test
